/* File: verilog/ffta_core.sv */
// Fault filter, external temperature calibration and alert mask bank
`timescale 1ns/1ps
module ffta_core (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] cmdCode,
   input wire logic cmdWrite,
   input wire logic cmdRead,
   input wire logic [55:0] cmdWrData,
   output logic [55:0] cmdRdData,
   output logic cmdRdValid,
   output logic cmdReject,
   input wire logic sampleValid,
   input wire logic ovViolation,
   input wire logic uvViolation,
   output logic ovFaultStart,
   output logic uvFaultStart,
   input wire logic temp2Req,
   input wire logic signed [31:0] extTempRaw,
   output logic signed [47:0] temp2Value,
   output logic temp2Valid,
   input wire logic [55:0] statusBits,
   output logic alertOutputPin
);
   logic rstMeta;
   logic rstSync;
   logic [7:0] ovuv_fault_filter_config;
   logic [15:0] ext_temp_scale;
   logic [15:0] ext_temp_offset;
   logic [55:0] alert_fault_mask;
   logic [4:0] violCnt [ffta_pkg::NUM_CH];
   logic [1:0] faultStart;
   logic [1:0] violIn;

   // Linear-11 to signed fixed point with 16 fraction bits
   function automatic logic signed [47:0] linToFix(input logic [15:0] v);
      logic signed [4:0] e;
      logic signed [47:0] m;
      e = v[ffta_pkg::LIN_EXP_MSB:ffta_pkg::LIN_EXP_LSB];
      m = 48'(signed'(v[ffta_pkg::LIN_MAN_MSB:0])) <<< ffta_pkg::FIX_FRAC;
      if (e >= 0) begin
         linToFix = m <<< e;
      end else begin
         linToFix = m >>> (-e);
      end
   endfunction

   // Reset released through two flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // Command decode and write range checks
   wire hitFilt = cmdCode == ffta_pkg::CMD_OVUV_FILTER;
   wire hitScale = cmdCode == ffta_pkg::CMD_SCALE;
   wire hitOffset = cmdCode == ffta_pkg::CMD_OFFSET;
   wire hitMask = cmdCode == ffta_pkg::CMD_ALERT_MASK;
   wire hitAny = hitFilt | hitScale | hitOffset | hitMask;
   wire signed [47:0] wrFix = linToFix(cmdWrData[15:0]);
   wire scaleOk = wrFix >= ffta_pkg::SCALE_MIN_FIX
      && wrFix <= ffta_pkg::SCALE_MAX_FIX;
   wire offsetOk = wrFix >= ffta_pkg::OFFSET_MIN_FIX
      && wrFix <= ffta_pkg::OFFSET_MAX_FIX;
   wire wrBad = !hitAny || (hitScale && !scaleOk)
      || (hitOffset && !offsetOk);
   wire [55:0] rdMux = hitFilt ? 56'(ovuv_fault_filter_config)
      : hitScale ? 56'(ext_temp_scale)
      : hitOffset ? 56'(ext_temp_offset)
      : hitMask ? alert_fault_mask : 56'h0;

   // Register writes; a refused value leaves the old one in place
   always_ff @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
         ovuv_fault_filter_config <= ffta_pkg::RST_OVUV_FILTER;
         ext_temp_scale <= ffta_pkg::RST_SCALE;
         ext_temp_offset <= ffta_pkg::RST_OFFSET;
         alert_fault_mask <= ffta_pkg::RST_ALERT_MASK;
      end else if (cmdWrite && !wrBad) begin
         if (hitFilt) begin
            ovuv_fault_filter_config <= cmdWrData[7:0];
         end
         if (hitScale) begin
            ext_temp_scale <= cmdWrData[15:0];
         end
         if (hitOffset) begin
            ext_temp_offset <= cmdWrData[15:0];
         end
         if (hitMask) begin
            alert_fault_mask <= cmdWrData;
         end
      end
   end

   // Read data and reject flag, one cycle after the strobe
   always_ff @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
         cmdRdData <= 56'h0;
         cmdRdValid <= 1'b0;
         cmdReject <= 1'b0;
      end else begin
         cmdRdValid <= cmdRead;
         cmdReject <= (cmdWrite && wrBad) || (cmdRead && !hitAny);
         if (cmdRead) begin
            cmdRdData <= rdMux;
         end
      end
   end

   // Consecutive violation filters, one per OV and UV
   assign violIn[ffta_pkg::CH_OV] = ovViolation;
   assign violIn[ffta_pkg::CH_UV] = uvViolation;
   wire [4:0] filtN =
      5'(ovuv_fault_filter_config[ffta_pkg::FILT_CNT_MSB:0]);
   genvar ch;
   generate
      for (ch = 0; ch < ffta_pkg::NUM_CH; ch++) begin : g_filt
         // Count saturates at N+1 so one run declares only once
         always_ff @(posedge sys_clk or negedge rstSync) begin
            if (!rstSync) begin
               violCnt[ch] <= 5'h0;
               faultStart[ch] <= 1'b0;
            end else if (sampleValid) begin
               if (!violIn[ch]) begin
                  violCnt[ch] <= 5'h0;
                  faultStart[ch] <= 1'b0;
               end else begin
                  if (violCnt[ch] <= filtN) begin
                     violCnt[ch] <= violCnt[ch] + 5'h1;
                  end
                  faultStart[ch] <= violCnt[ch] == filtN;
               end
            end else begin
               faultStart[ch] <= 1'b0;
            end
         end
      end
   endgenerate
   assign ovFaultStart = faultStart[ffta_pkg::CH_OV];
   assign uvFaultStart = faultStart[ffta_pkg::CH_UV];

   // Calibrated reading; the divide is wide but one-shot per request
   wire signed [47:0] scaleFix = linToFix(ext_temp_scale);
   wire signed [47:0] offFix = linToFix(ext_temp_offset);
   // Raw is Q.16; one extra shift keeps the quotient in Q.16
   wire signed [79:0] rawShift =
      80'(extTempRaw) <<< ffta_pkg::FIX_FRAC;
   wire signed [79:0] quot = rawShift / 80'(scaleFix);
   always_ff @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
         temp2Value <= 48'sh0;
         temp2Valid <= 1'b0;
      end else begin
         temp2Valid <= temp2Req;
         if (temp2Req) begin
            temp2Value <= 48'(quot) - offFix;
         end
      end
   end

   // Alert: any unmasked status bit, byte 5 never counts
   wire [55:0] usedBits = ~(56'hff << (8 * ffta_pkg::UNUSED_MASK_BYTE));
   wire alertNext = |(statusBits & ~alert_fault_mask & usedBits);
   always_ff @(posedge sys_clk or negedge rstSync) begin
      if (!rstSync) begin
         alertOutputPin <= 1'b0;
      end else begin
         alertOutputPin <= alertNext;
      end
   end

   // Checks
   ovDeclare_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      ovFaultStart |-> $past(sampleValid) && $past(ovViolation)
      && $past(violCnt[ffta_pkg::CH_OV]) == $past(filtN))
      else $error("OV declared at wrong count");
   uvDeclare_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      sampleValid && uvViolation && violCnt[ffta_pkg::CH_UV] == filtN
      |=> uvFaultStart)
      else $error("UV not declared at N+1");
   cntClear_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      sampleValid && !ovViolation |=> violCnt[ffta_pkg::CH_OV] == 5'h0)
      else $error("Count not cleared");
   filtWrite_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      cmdWrite && hitFilt
      |=> ovuv_fault_filter_config == $past(cmdWrData[7:0]))
      else $error("Filter byte not stored");
   scaleRej_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      cmdWrite && hitScale && !scaleOk
      |=> $stable(ext_temp_scale) && cmdReject)
      else $error("Bad scale accepted");
   offsetRej_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      cmdWrite && hitOffset && !offsetOk
      |=> $stable(ext_temp_offset) && cmdReject)
      else $error("Bad offset accepted");
   // Unit scale and zero offset must pass the raw reading through
   tempCal_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      temp2Req && ext_temp_scale == ffta_pkg::RST_SCALE
      && ext_temp_offset == ffta_pkg::RST_OFFSET
      |=> temp2Valid && temp2Value == 48'($past(extTempRaw)))
      else $error("Calibrated reading wrong");
   maskGate_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      (statusBits & usedBits & ~alert_fault_mask) == 56'h0
      |=> !alertOutputPin)
      else $error("Masked fault reached alert");
   byteFive_a: assert property (
      @(posedge sys_clk) disable iff (!rstSync)
      (statusBits & ~(56'hff << (8 * ffta_pkg::UNUSED_MASK_BYTE))) == 56'h0
      |=> !alertOutputPin)
      else $error("Unused byte raised alert");
   maskReset_a: assert property (
      @(posedge sys_clk)
      $rose(rstSync) |-> alert_fault_mask == 56'h0)
      else $error("Mask not zero after reset");
endmodule

/* File: pkg/ffta_pkg.sv */
// Command codes, layouts and reset values of the fault filter/cal/mask bank
package ffta_pkg;
   // Command codes
   localparam logic [7:0] CMD_OVUV_FILTER = 8'hd8;
   localparam logic [7:0] CMD_SCALE = 8'hd9;
   localparam logic [7:0] CMD_OFFSET = 8'hda;
   localparam logic [7:0] CMD_ALERT_MASK = 8'hdb;
   // Reset values
   localparam logic [7:0] RST_OVUV_FILTER = 8'h00;
   localparam logic [15:0] RST_SCALE = 16'hba00;
   localparam logic [15:0] RST_OFFSET = 16'h0000;
   localparam logic [55:0] RST_ALERT_MASK = 56'h00000000000000;
   // Field layout
   localparam int FILT_CNT_MSB = 3;
   localparam int LIN_EXP_MSB = 15;
   localparam int LIN_EXP_LSB = 11;
   localparam int LIN_MAN_MSB = 10;
   localparam int UNUSED_MASK_BYTE = 5;
   localparam int MASK_BYTES = 7;
   localparam int DATA_W = 56;
   // Fixed point used for range checks and the calibrated reading
   localparam int FIX_W = 48;
   localparam int FIX_FRAC = 16;
   // 0.1 rounded up so that values just below it are still refused
   localparam logic signed [47:0] SCALE_MIN_FIX = 48'sh00000000199a;
   localparam logic signed [47:0] SCALE_MAX_FIX = 48'sh0000000a0000;
   localparam logic signed [47:0] OFFSET_MIN_FIX = -48'sh000000640000;
   localparam logic signed [47:0] OFFSET_MAX_FIX = 48'sh000000640000;
   // Filter channels
   localparam int CH_OV = 0;
   localparam int CH_UV = 1;
   localparam int NUM_CH = 2;
endpackage

/* File: tb/ffta_host_model.sv */
// Host model that issues command accesses to the bank
`timescale 1ns/1ps
module ffta_host_model (
   input wire logic sys_clk,
   output logic [7:0] cmdCode,
   output logic cmdWrite,
   output logic cmdRead,
   output logic [55:0] cmdWrData,
   input wire logic [55:0] cmdRdData,
   input wire logic cmdRdValid,
   input wire logic cmdReject
);
   // Idle bus at time zero
   initial begin
      cmdCode = 8'h00;
      cmdWrite = 1'b0;
      cmdRead = 1'b0;
      cmdWrData = 56'h0;
   end
   // Bus inverted after use so stale data never passes
   task automatic access(input logic wr, input logic [7:0] code,
         input logic [55:0] dat, output logic [55:0] rd, output logic rej);
      @(negedge sys_clk);
      cmdCode = code;
      cmdWrData = dat;
      cmdWrite = wr;
      cmdRead = !wr;
      @(negedge sys_clk);
      cmdWrite = 1'b0;
      cmdRead = 1'b0;
      cmdCode = ~code;
      cmdWrData = ~dat;
      rd = cmdRdValid ? cmdRdData : 56'hx;
      rej = cmdReject;
   endtask
endmodule

/* File: tb/ffta_core_tb_top.sv */
// Self-checking bench for the filter, calibration and mask bank
`timescale 1ns/1ps
module ffta_core_tb_top;
   logic sys_clk, rst_n, cmdWrite, cmdRead, cmdRdValid, cmdReject, r;
   logic sampleValid, ovViolation, uvViolation, ovFaultStart, uvFaultStart;
   logic temp2Req, temp2Valid, alertOutputPin;
   logic [7:0] cmdCode;
   logic [55:0] cmdWrData, cmdRdData, statusBits, d;
   logic signed [31:0] extTempRaw;
   logic signed [47:0] temp2Value;
   logic [3:0] fv [8] = '{4'h8, 4'ha, 4'h8, 4'h0, 4'h4, 4'h0, 4'h4, 4'h5};
   int failures = 0;
   int checkCount = 0;
   ffta_core i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmdCode(cmdCode),
      .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdWrData(cmdWrData),
      .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cmdReject(cmdReject),
      .sampleValid(sampleValid), .ovViolation(ovViolation),
      .uvViolation(uvViolation), .ovFaultStart(ovFaultStart),
      .uvFaultStart(uvFaultStart), .temp2Req(temp2Req),
      .extTempRaw(extTempRaw), .temp2Value(temp2Value),
      .temp2Valid(temp2Valid), .statusBits(statusBits),
      .alertOutputPin(alertOutputPin));
   ffta_host_model i_host (.sys_clk(sys_clk), .cmdCode(cmdCode),
      .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdWrData(cmdWrData),
      .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cmdReject(cmdReject));
   // Clock at 8 ns
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [55:0] e,
         input logic [55:0] g);
      checkCount++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] c, input logic [55:0] e);
      i_host.access(1'b0, c, 56'h0, d, r);
      chk("read data", e, d);
   endtask
   task automatic wr(input logic [7:0] c, input logic [55:0] v,
         input logic er);
      i_host.access(1'b1, c, v, d, r);
      chk("reject", {55'h0, er}, {55'h0, r});
   endtask
   task automatic finish_test;
      $display("Checks %0d failures %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog, far beyond the fewer than a hundred cycles the tests need
   initial begin
      #20000;
      failures++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      {sampleValid, ovViolation, uvViolation, temp2Req} = 4'h0;
      extTempRaw = 32'sh00640000;
      statusBits = 56'h01;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("alert", 56'h1, {55'h0, alertOutputPin});
      rd(ffta_pkg::CMD_OVUV_FILTER, 56'h00);
      rd(ffta_pkg::CMD_SCALE, 56'hba00);
      rd(ffta_pkg::CMD_OFFSET, 56'h0000);
      rd(ffta_pkg::CMD_ALERT_MASK, 56'h0);
      // Default calibration passes the raw reading through
      @(negedge sys_clk);
      temp2Req = 1'b1;
      @(negedge sys_clk);
      temp2Req = 1'b0;
      chk("temp default", 56'h640000, 56'(temp2Value));
      wr(ffta_pkg::CMD_SCALE, 56'h0014, 1'b1);
      wr(ffta_pkg::CMD_SCALE, 56'hd801, 1'b1);
      wr(ffta_pkg::CMD_SCALE, 56'hf801, 1'b0);
      wr(ffta_pkg::CMD_SCALE, 56'h0002, 1'b0);
      rd(ffta_pkg::CMD_SCALE, 56'h0002);
      wr(ffta_pkg::CMD_OFFSET, 56'h00c8, 1'b1);
      wr(ffta_pkg::CMD_OFFSET, 56'h0005, 1'b0);
      rd(ffta_pkg::CMD_OFFSET, 56'h0005);
      // Calibrated reading: 100 / 2.0 - 5 = 45
      @(negedge sys_clk);
      temp2Req = 1'b1;
      @(negedge sys_clk);
      temp2Req = 1'b0;
      chk("temp valid", 56'h1, {55'h0, temp2Valid});
      chk("temp value", 56'h2d0000, 56'(temp2Value));
      wr(ffta_pkg::CMD_OVUV_FILTER, 56'h01, 1'b0);
      rd(ffta_pkg::CMD_OVUV_FILTER, 56'h01);
      // Two consecutive violations declare once; runs broken by clean samples must not declare
      foreach (fv[i]) begin
         @(negedge sys_clk);
         {sampleValid, ovViolation, uvViolation} = {1'b1, fv[i][3:2]};
         @(negedge sys_clk);
         sampleValid = 1'b0;
         chk("ov fault", {55'h0, fv[i][1]}, {55'h0, ovFaultStart});
         chk("uv fault", {55'h0, fv[i][0]}, {55'h0, uvFaultStart});
      end
      wr(ffta_pkg::CMD_ALERT_MASK, 56'h01, 1'b0);
      rd(ffta_pkg::CMD_ALERT_MASK, 56'h01);
      @(negedge sys_clk);
      chk("alert masked", 56'h0, {55'h0, alertOutputPin});
      // Byte 6 unmasked raises the pin, byte 5 never does
      statusBits = 56'h01000000000001;
      repeat (2) @(negedge sys_clk);
      chk("alert byte6", 56'h1, {55'h0, alertOutputPin});
      statusBits = 56'h00ff0000000000;
      repeat (2) @(negedge sys_clk);
      chk("alert byte5", 56'h0, {55'h0, alertOutputPin});
      // Reset in mid-run must return the mask and scale to their reset values
      rst_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      rd(ffta_pkg::CMD_ALERT_MASK, 56'h0);
      rd(ffta_pkg::CMD_SCALE, 56'hba00);
      finish_test();
   end
endmodule
